/* logic/csrc_pkg.sv */
// constants shared by the clock, sleep and reset control block
// assumes one 50 MHz reference clock and a synchronous high reset
package csrc_pkg;

	// =========================================================
	// timing
	localparam int unsigned REF_CLK_HZ      = 50_000_000;
	localparam int unsigned REF_PERIOD_NS   = 20;
	localparam int unsigned RST_PIN_MIN_NS  = 500;
	localparam int unsigned RST_PIN_MIN_CYC =
		(RST_PIN_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS; // round up
	localparam int unsigned INT_RC_HZ       = 1_000_000;
	localparam int unsigned INT_RC_HALF_CYC = REF_CLK_HZ / (2 * INT_RC_HZ);

	// =========================================================
	// clock source fuse code boundaries, 1 = unprogrammed
	localparam logic [3:0] FUSE_XTAL_LO   = 4'hA;
	localparam logic [3:0] FUSE_LFXTAL_LO = 4'h8;
	localparam logic [3:0] FUSE_EXTRC_LO  = 4'h5;
	localparam logic [3:0] FUSE_INTRC_LO  = 4'h2;
	localparam logic [3:0] FUSE_RESET_VAL = 4'hF;

	// =========================================================
	// port layout: four 8-bit ports, jtag pins on the third
	localparam int unsigned PORT_PINS = 32;
	localparam int unsigned PIN_TCK   = 18;
	localparam int unsigned PIN_TMS   = 19;
	localparam int unsigned PIN_TDI   = 21;

	// =========================================================
	// clock sources, one-hot
	typedef enum logic [4:0] {
		CSRC_XTAL   = 5'h01,
		CSRC_LFXTAL = 5'h02,
		CSRC_EXTRC  = 5'h04,
		CSRC_INTRC  = 5'h08,
		CSRC_EXTCLK = 5'h10
	} csrc_src_t;

	// sleep mode codes
	typedef enum logic [2:0] {
		CSRC_IDLE    = 3'h0,
		CSRC_ADC_NR  = 3'h1,
		CSRC_PDOWN   = 3'h2,
		CSRC_PSAVE   = 3'h3,
		CSRC_STANDBY = 3'h6,
		CSRC_EXT_STB = 3'h7
	} csrc_mode_t;

	// sleep controller states, one-hot
	typedef enum logic [1:0] {
		CSRC_ST_RUN   = 2'h1,
		CSRC_ST_SLEEP = 2'h2
	} csrc_state_t;

endpackage

/* logic/csrc_rst_filter.sv */
// reset pin filter: synchronises the pin and qualifies long lows
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps

module csrc_rst_filter #(
	parameter int unsigned MIN_CYC = csrc_pkg::RST_PIN_MIN_CYC
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic rst_pin_n,
	output logic      pin_rst
);

	// refuse widths the 16-bit counter cannot reach
	if (MIN_CYC < 1 || MIN_CYC > 65534) begin : g_bad_min
		$error("csrc_rst_filter: MIN_CYC out of range");
	end

	// =========================================================
	// synchroniser and low counter
	logic        sync1_r, sync2_r;
	logic [15:0] low_cnt_r, low_cnt_nxt;
	logic        rst_r, rst_nxt;

	// count lows, saturating one past the least width
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		rst_nxt     = 1'b0;
		if (sync2_r) begin
			low_cnt_nxt = 16'h0000;
		end else if (low_cnt_r <= 16'(MIN_CYC)) begin
			low_cnt_nxt = low_cnt_r + 16'h0001;
		end
		if (!sync2_r && low_cnt_r >= 16'(MIN_CYC)) begin
			rst_nxt = 1'b1; // held past the least width
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1_r   <= 1'b1;
			sync2_r   <= 1'b1;
			low_cnt_r <= 16'h0000;
			rst_r     <= 1'b0;
		end else begin
			sync1_r   <= rst_pin_n;
			sync2_r   <= sync1_r;
			low_cnt_r <= low_cnt_nxt;
			rst_r     <= rst_nxt;
		end
	end

	assign pin_rst = rst_r;

endmodule

/* logic/csrc_top.sv */
// clock source selection, sleep-mode clock gating and reset pin handling
// assumes static fuse inputs and a ref_clk that always runs
`timescale 1ns/1ps

// Behaviour
// - four fuse bits choose crystal, low-freq crystal, ext RC, internal RC, ext clock
// - internal RC choice clocks the chip from an on-chip 1 MHz oscillator
// - idle stops cpu clock; sram, timers, spi, interrupts keep clocks
// - power-down stops main oscillator and all else; wake on interrupt or reset
// - power-save keeps async timer and its oscillator running
// - adc noise mode stops cpu and io except async timer and adc
// - standby keeps crystal oscillator running, all other logic asleep
// - extended standby keeps main and async timer oscillators running
// - reset pin low beyond 500 ns resets the device, even without clock (here the low is counted on ref_clk, so the clock is needed)
// - reset tri-states all port pins asynchronously
// - with jtag enabled, pull-ups on tdi, tms, tck stay on in reset
module csrc_top #(
	parameter int unsigned RST_MIN_CYC = csrc_pkg::RST_PIN_MIN_CYC,
	parameter int unsigned RC_HALF_CYC = csrc_pkg::INT_RC_HALF_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        rst_pin_n,
	input  wire logic [3:0]  clock_source_select_fuses,
	input  wire logic        sleep_req,
	input  wire logic [2:0]  sleep_mode,
	input  wire logic        wake_irq,
	input  wire logic        jtag_en,
	input  wire logic [31:0] port_out,
	input  wire logic [31:0] port_dir,
	input  wire logic [31:0] port_pullup_req,
	output logic [31:0]      port_o,
	output logic [31:0]      port_drv_n,
	output logic [31:0]      port_pullup,
	output logic [4:0]       clk_src,
	output logic             osc_amp_en,
	output logic             int_rc_clk,
	output logic             dev_rst,
	output logic             asleep,
	output logic             cpu_clk_en,
	output logic             io_clk_en,
	output logic             adc_clk_en,
	output logic             irq_clk_en,
	output logic             async_tmr_en,
	output logic             main_osc_en,
	output logic             async_osc_en
);

	// refuse timing values the counters cannot hold
	if (RST_MIN_CYC < 1 || RC_HALF_CYC < 1 || RC_HALF_CYC > 255) begin : g_bad_timing
		$error("csrc_top: timing parameter out of range");
	end

	// =========================================================
	// fuse decode
	function automatic csrc_pkg::csrc_src_t decode_src(input logic [3:0] f);
		if (f >= csrc_pkg::FUSE_XTAL_LO) begin
			decode_src = csrc_pkg::CSRC_XTAL;
		end else if (f >= csrc_pkg::FUSE_LFXTAL_LO) begin
			decode_src = csrc_pkg::CSRC_LFXTAL;
		end else if (f >= csrc_pkg::FUSE_EXTRC_LO) begin
			decode_src = csrc_pkg::CSRC_EXTRC;
		end else if (f >= csrc_pkg::FUSE_INTRC_LO) begin
			decode_src = csrc_pkg::CSRC_INTRC;
		end else begin
			decode_src = csrc_pkg::CSRC_EXTCLK;
		end
	endfunction

	// =========================================================
	// reset pin qualification
	logic pin_rst;

	csrc_rst_filter #(
		.MIN_CYC (RST_MIN_CYC)
	) u_rst_filter (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.rst_pin_n (rst_pin_n),
		.pin_rst   (pin_rst)
	);

	logic any_rst;
	assign any_rst = sys_rst | pin_rst;
	assign dev_rst = any_rst;

	// =========================================================
	// clock source register, refreshed from the fuses after reset
	csrc_pkg::csrc_src_t src_r, src_nxt;

	always_comb begin
		src_nxt = decode_src(clock_source_select_fuses);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			src_r <= csrc_pkg::CSRC_XTAL;
		end else begin
			src_r <= src_nxt;
		end
	end

	assign clk_src = src_r;

	// =========================================================
	// sleep state machine
	csrc_pkg::csrc_state_t st_r, st_nxt;
	logic [2:0]            mode_r, mode_nxt;

	always_comb begin
		st_nxt   = st_r;
		mode_nxt = mode_r;
		unique case (st_r)
			csrc_pkg::CSRC_ST_RUN: begin
				if (sleep_req) begin
					st_nxt   = csrc_pkg::CSRC_ST_SLEEP;
					mode_nxt = sleep_mode;
				end
			end
			csrc_pkg::CSRC_ST_SLEEP: begin
				if (wake_irq) begin
					st_nxt = csrc_pkg::CSRC_ST_RUN;
				end
			end
			default: begin
				st_nxt = csrc_pkg::CSRC_ST_RUN;
			end
		endcase
	end

	// reset wakes; register contents elsewhere are untouched by sleep
	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			st_r   <= csrc_pkg::CSRC_ST_RUN;
			mode_r <= csrc_pkg::CSRC_IDLE;
		end else begin
			st_r   <= st_nxt;
			mode_r <= mode_nxt;
		end
	end

	// =========================================================
	// domain gating per sleep mode
	logic cpu_nxt, io_nxt, adc_nxt, irq_nxt, atmr_nxt, mosc_nxt, aosc_nxt;
	logic cpu_r, io_r, adc_r, irq_r, atmr_r, mosc_r, aosc_r;

	always_comb begin
		cpu_nxt  = 1'b1;
		io_nxt   = 1'b1;
		adc_nxt  = 1'b1;
		irq_nxt  = 1'b1;
		atmr_nxt = 1'b1;
		mosc_nxt = 1'b1;
		aosc_nxt = 1'b1;
		if (st_nxt == csrc_pkg::CSRC_ST_SLEEP) begin
			cpu_nxt = 1'b0;
			unique case (mode_nxt)
				csrc_pkg::CSRC_IDLE: begin
					cpu_nxt = 1'b0; // others keep running
				end
				csrc_pkg::CSRC_ADC_NR: begin
					io_nxt  = 1'b0; // cpu and io stop; adc, irq, async timer and both oscillators kept
				end
				csrc_pkg::CSRC_PDOWN: begin
					io_nxt   = 1'b0; // everything frozen
					adc_nxt  = 1'b0;
					irq_nxt  = 1'b0;
					atmr_nxt = 1'b0;
					mosc_nxt = 1'b0;
					aosc_nxt = 1'b0;
				end
				csrc_pkg::CSRC_PSAVE: begin
					io_nxt   = 1'b0; // async timebase kept
					adc_nxt  = 1'b0;
					irq_nxt  = 1'b0;
					mosc_nxt = 1'b0;
				end
				csrc_pkg::CSRC_STANDBY: begin
					io_nxt   = 1'b0; // crystal kept for fast start
					adc_nxt  = 1'b0;
					irq_nxt  = 1'b0;
					atmr_nxt = 1'b0;
					aosc_nxt = 1'b0;
				end
				csrc_pkg::CSRC_EXT_STB: begin
					io_nxt   = 1'b0; // both oscillators kept
					adc_nxt  = 1'b0;
					irq_nxt  = 1'b0;
				end
				default: begin
					cpu_nxt = 1'b0; // unused code acts as idle
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			cpu_r  <= 1'b1;
			io_r   <= 1'b1;
			adc_r  <= 1'b1;
			irq_r  <= 1'b1;
			atmr_r <= 1'b1;
			mosc_r <= 1'b1;
			aosc_r <= 1'b1;
		end else begin
			cpu_r  <= cpu_nxt;
			io_r   <= io_nxt;
			adc_r  <= adc_nxt;
			irq_r  <= irq_nxt;
			atmr_r <= atmr_nxt;
			mosc_r <= mosc_nxt;
			aosc_r <= aosc_nxt;
		end
	end

	assign asleep       = (st_r == csrc_pkg::CSRC_ST_SLEEP);
	assign cpu_clk_en   = cpu_r;
	assign io_clk_en    = io_r;
	assign adc_clk_en   = adc_r;
	assign irq_clk_en   = irq_r;
	assign async_tmr_en = atmr_r;
	assign main_osc_en  = mosc_r;
	assign async_osc_en = aosc_r;

	// amplifier only for crystal and resonator sources
	assign osc_amp_en = mosc_r &
		((src_r == csrc_pkg::CSRC_XTAL) | (src_r == csrc_pkg::CSRC_LFXTAL));

	// =========================================================
	// internal rc oscillator, divided from the reference
	logic [7:0] rc_cnt_r, rc_cnt_nxt;
	logic       rc_clk_r, rc_clk_nxt;
	logic       rc_run;
	assign rc_run = mosc_r & (src_r == csrc_pkg::CSRC_INTRC);

	always_comb begin
		rc_cnt_nxt = rc_cnt_r;
		rc_clk_nxt = rc_clk_r;
		if (!rc_run) begin
			rc_cnt_nxt = 8'h00;
			rc_clk_nxt = 1'b0;
		end else if (rc_cnt_r == 8'(RC_HALF_CYC - 1)) begin
			rc_cnt_nxt = 8'h00;
			rc_clk_nxt = ~rc_clk_r; // 1 MHz square wave
		end else begin
			rc_cnt_nxt = rc_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rc_cnt_r <= 8'h00;
			rc_clk_r <= 1'b0;
		end else begin
			rc_cnt_r <= rc_cnt_nxt;
			rc_clk_r <= rc_clk_nxt;
		end
	end

	assign int_rc_clk = rc_clk_r;

	// =========================================================
	// port pins: data registered, enables forced off in reset
	logic [31:0] port_o_r, port_o_nxt;
	logic        pins_off;

	// raw pin low tri-states at once, no clock needed
	assign pins_off = ~rst_pin_n | any_rst;

	always_comb begin
		port_o_nxt = port_out;
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			port_o_r <= 32'h0000_0000;
		end else begin
			port_o_r <= port_o_nxt;
		end
	end

	assign port_o = port_o_r;

	for (genvar gi = 0; gi < 32; gi++) begin : g_pin
		localparam bit IS_JTAG = (gi == csrc_pkg::PIN_TCK) ||
			(gi == csrc_pkg::PIN_TMS) || (gi == csrc_pkg::PIN_TDI);
		// low enable means driven
		assign port_drv_n[gi] = ~port_dir[gi] | pins_off;
		if (IS_JTAG) begin : g_jtag
			assign port_pullup[gi] = jtag_en |
				(port_pullup_req[gi] & ~port_dir[gi] & ~pins_off);
		end else begin : g_plain
			assign port_pullup[gi] = port_pullup_req[gi] & ~port_dir[gi] & ~pins_off;
		end
	end

endmodule

/* verification/csrc_rst_model.sv */
// external reset circuit: pulls the reset pin low on request
// driven by the bench on ref_clk
`timescale 1ns/1ps
module csrc_rst_model (
	input wire logic       ref_clk,
	input wire logic       go,
	input wire logic [7:0] low_cyc,
	output logic           rst_pin_n
);
	// pin idles high through its pull-up
	initial rst_pin_n = 1'b1;
	// low pulse of the requested length
	always @(posedge ref_clk) begin
		if (go) begin
			rst_pin_n <= 1'b0;
			repeat (low_cyc) @(posedge ref_clk);
			rst_pin_n <= 1'b1;
		end
	end
endmodule

/* verification/csrc_top_properties.sv */
// checker for clock select, sleep gating and reset pin handling
// bound to csrc_top from the bench top; sees its ports only
`timescale 1ns/1ps
module csrc_top_properties #(
	parameter int unsigned RST_MIN_CYC = 25
) (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        rst_pin_n,
	input wire logic [3:0]  clock_source_select_fuses,
	input wire logic        sleep_req,
	input wire logic [2:0]  sleep_mode,
	input wire logic        wake_irq,
	input wire logic        jtag_en,
	input wire logic [31:0] port_drv_n,
	input wire logic [31:0] port_pullup,
	input wire logic [4:0]  clk_src,
	input wire logic        dev_rst,
	input wire logic        asleep,
	input wire logic        cpu_clk_en,
	input wire logic        io_clk_en,
	input wire logic        adc_clk_en,
	input wire logic        irq_clk_en,
	input wire logic        async_tmr_en,
	input wire logic        main_osc_en,
	input wire logic        async_osc_en
);
	// ====
	// helpers
	logic [6:0] en;
	logic [4:0] src_exp;
	logic [7:0] low_r;
	logic [7:0] low_nxt;
	// enables, cpu down to async osc
	assign en = {cpu_clk_en, io_clk_en, adc_clk_en, irq_clk_en, async_tmr_en, main_osc_en,
		async_osc_en};
	// source expected for the fuse code
	always_comb begin
		case (clock_source_select_fuses) inside
			[4'hA:4'hF]: src_exp = 5'h01;
			[4'h8:4'h9]: src_exp = 5'h02;
			[4'h5:4'h7]: src_exp = 5'h04;
			[4'h2:4'h4]: src_exp = 5'h08;
			default:     src_exp = 5'h10;
		endcase
	end
	// run of low samples on the reset pin
	always_comb begin
		low_nxt = rst_pin_n ? 8'h00 : low_r + {7'h00, low_r != 8'hFF};
	end
	always_ff @(posedge ref_clk) begin
		low_r <= low_nxt;
	end
	// ====
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_go(logic [2:0] m);
		!asleep && !dev_rst && sleep_req && sleep_mode == m;
	endsequence
	sequence s_wake;
		asleep && !dev_rst && wake_irq;
	endsequence
	a_fuse_src: assert property (
		!$past(sys_rst) && $stable(clock_source_select_fuses) |-> clk_src == src_exp)
		else $error("clock source decode wrong");
	a_idle_gate: assert property (s_go(3'h0) |=> asleep && en == 7'h3F)
		else $error("idle gating wrong");
	a_pdown_off: assert property (s_go(3'h2) |=> asleep && en == 7'h00)
		else $error("power-down gating wrong");
	a_psave_tmr: assert property (s_go(3'h3) |=> asleep && en == 7'h05)
		else $error("power-save gating wrong");
	a_adc_quiet: assert property (s_go(3'h1) |=> asleep && en == 7'h1F)
		else $error("adc quiet gating wrong");
	a_stby_osc: assert property (s_go(3'h6) |=> asleep && en == 7'h02)
		else $error("standby gating wrong");
	a_xstby_osc: assert property (s_go(3'h7) |=> asleep && en == 7'h07)
		else $error("extended standby gating wrong");
	a_wake_all: assert property (s_wake |=> !asleep && en == 7'h7F)
		else $error("wake did not restore clocks");
	a_pin_rst: assert property (low_r >= RST_MIN_CYC + 5 |-> dev_rst)
		else $error("long reset pin low ignored");
	a_pin_hiz: assert property (!rst_pin_n || dev_rst |-> port_drv_n == '1)
		else $error("pins driven during reset");
	a_jtag_pull: assert property (
		jtag_en |-> port_pullup[21] && port_pullup[19:18] == 2'h3)
		else $error("jtag pull-ups off");
endmodule

/* verification/tb.sv */
// top bench: fuse decode, internal rc, sleep modes, reset pin
// drives csrc_top and the reset pin model from ref_clk
`timescale 1ns/1ps
module tb;
	localparam int unsigned RMIN = 3;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  clock_source_select_fuses = 4'hF;
	logic        sleep_req = 1'b0;
	logic [2:0]  sleep_mode = 3'h0;
	logic        wake_irq = 1'b0;
	logic        jtag_en = 1'b0;
	logic [31:0] port_out = 32'hA5A5_5A5A;
	logic [31:0] port_dir = 32'hFFFF_FFFF;
	logic [31:0] port_pullup_req = 32'hFFFF_FFFF;
	logic        go = 1'b0;
	logic [7:0]  low_cyc = 8'h00;
	logic        rst_pin_n;
	logic [31:0] port_o, port_drv_n, port_pullup;
	logic [4:0]  clk_src;
	logic        osc_amp_en, int_rc_clk, dev_rst, asleep;
	logic        cpu_clk_en, io_clk_en, adc_clk_en, irq_clk_en;
	logic        async_tmr_en, main_osc_en, async_osc_en;
	logic [6:0]  en;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	assign en = {cpu_clk_en, io_clk_en, adc_clk_en, irq_clk_en, async_tmr_en, main_osc_en,
		async_osc_en};
	csrc_top #(
		.RST_MIN_CYC (RMIN),
		.RC_HALF_CYC (2)
	) csrc_top_inst (
		.ref_clk                   (ref_clk),
		.sys_rst                   (sys_rst),
		.rst_pin_n                 (rst_pin_n),
		.clock_source_select_fuses (clock_source_select_fuses),
		.sleep_req                 (sleep_req),
		.sleep_mode                (sleep_mode),
		.wake_irq                  (wake_irq),
		.jtag_en                   (jtag_en),
		.port_out                  (port_out),
		.port_dir                  (port_dir),
		.port_pullup_req           (port_pullup_req),
		.port_o                    (port_o),
		.port_drv_n                (port_drv_n),
		.port_pullup               (port_pullup),
		.clk_src                   (clk_src),
		.osc_amp_en                (osc_amp_en),
		.int_rc_clk                (int_rc_clk),
		.dev_rst                   (dev_rst),
		.asleep                    (asleep),
		.cpu_clk_en                (cpu_clk_en),
		.io_clk_en                 (io_clk_en),
		.adc_clk_en                (adc_clk_en),
		.irq_clk_en                (irq_clk_en),
		.async_tmr_en              (async_tmr_en),
		.main_osc_en               (main_osc_en),
		.async_osc_en              (async_osc_en)
	);
	csrc_rst_model csrc_rst_model_inst (
		.ref_clk   (ref_clk),
		.go        (go),
		.low_cyc   (low_cyc),
		.rst_pin_n (rst_pin_n)
	);
	// reference clock
	always #10 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	// ====
	// tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_rst(input logic [3:0] f);
		@(posedge ref_clk) clock_source_select_fuses <= f;
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic t_fuses();
		logic [31:0] e;
		for (int f = 0; f < 16; f++) begin
			e = f > 9 ? 32'h01 : f > 7 ? 32'h02 : f > 4 ? 32'h04 : f > 1 ? 32'h08 : 32'h10;
			do_rst(4'(f));
			chk("clk_src", e, 32'(clk_src));
			chk("amp_en", 32'(f > 7), 32'(osc_amp_en));
		end
		$display("test fuses done");
	endtask
	task automatic t_rc();
		int   n;
		logic p;
		n = 0;
		do_rst(4'h3);
		repeat (4) @(posedge ref_clk);
		#1;
		p = int_rc_clk;
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			if (int_rc_clk !== p) n++;
			p = int_rc_clk;
		end
		chk("rc_toggles", 32'h14, n);
		$display("test rc done");
	endtask
	task automatic t_sleep();
		logic [2:0] md [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
		logic [6:0] ex [8] = '{7'h3F, 7'h1F, 7'h00, 7'h05, 7'h02, 7'h07, 7'h3F, 7'h3F};
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk) sleep_req <= 1'b1;
			sleep_mode <= md[i];
			@(posedge ref_clk) sleep_req <= 1'b0;
			#1;
			chk("sleep_en", 32'({1'b1, ex[i]}), 32'({asleep, en}));
			@(posedge ref_clk) sleep_req <= 1'b1;
			sleep_mode <= 3'h0;
			@(posedge ref_clk) sleep_req <= 1'b0;
			#1;
			chk("resleep_en", 32'({1'b1, ex[i]}), 32'({asleep, en}));
			@(posedge ref_clk) wake_irq <= 1'b1;
			@(posedge ref_clk) wake_irq <= 1'b0;
			#1;
			chk("wake_en", 32'h7F, 32'({asleep, en}));
		end
		$display("test sleep done");
	endtask
	task automatic t_pin();
		logic seen;
		seen = 1'b0;
		@(posedge ref_clk) low_cyc <= 8'(RMIN - 1);
		go <= 1'b1;
		@(posedge ref_clk) go <= 1'b0;
		#1;
		chk("drv_n", 32'hFFFF_FFFF, port_drv_n);
		chk("pullup_off", 32'h0, port_pullup);
		repeat (10) begin
			@(posedge ref_clk);
			#1;
			seen = seen | dev_rst;
		end
		chk("short_rst", 32'h0, 32'(seen));
		@(posedge ref_clk) low_cyc <= 8'h0C;
		go <= 1'b1;
		jtag_en <= 1'b1;
		@(posedge ref_clk) go <= 1'b0;
		repeat (10) @(posedge ref_clk);
		#1;
		chk("long_rst", 32'h1, 32'(dev_rst));
		chk("pullup", 32'h002C_0000, port_pullup);
		chk("port_o_rst", 32'h0, port_o);
		repeat (8) @(posedge ref_clk);
		#1;
		chk("rst_end", 32'h0, 32'(dev_rst));
		chk("port_o_run", port_out, port_o);
		chk("drv_n_run", 32'h0, port_drv_n);
		$display("test pin done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_fuses();
		t_rc();
		t_sleep();
		t_pin();
		end_of_test();
	end
endmodule
bind csrc_top csrc_top_properties #(
	.RST_MIN_CYC (RST_MIN_CYC)
) csrc_top_properties_inst (
	.ref_clk                   (ref_clk),
	.sys_rst                   (sys_rst),
	.rst_pin_n                 (rst_pin_n),
	.clock_source_select_fuses (clock_source_select_fuses),
	.sleep_req                 (sleep_req),
	.sleep_mode                (sleep_mode),
	.wake_irq                  (wake_irq),
	.jtag_en                   (jtag_en),
	.port_drv_n                (port_drv_n),
	.port_pullup               (port_pullup),
	.clk_src                   (clk_src),
	.dev_rst                   (dev_rst),
	.asleep                    (asleep),
	.cpu_clk_en                (cpu_clk_en),
	.io_clk_en                 (io_clk_en),
	.adc_clk_en                (adc_clk_en),
	.irq_clk_en                (irq_clk_en),
	.async_tmr_en              (async_tmr_en),
	.main_osc_en               (main_osc_en),
	.async_osc_en              (async_osc_en)
);
